// File: hw/dpc_defs.svh
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DPC_ADDR_FIXED 12'h30F
`define DPC_ADDR_STEP 12'h314
`define DPC_ADDR_SLEW 12'h316
`define DPC_ADDR_CTRL 12'hA0C
`define DPC_ADDR_STATUS 12'hA0D
`define DPC_FIXED_BYTES 5
`define DPC_STEP_BYTES 2
// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define DPC_BIT_INC 0
`define DPC_BIT_DEC 1
`define DPC_BIT_CLR 2
`define DPC_BIT_LOCKED 0
// ----------------------------------------
// Lock detector levels
// ----------------------------------------
`define DPC_LVL_EMPTY 13'sh1800
`define DPC_LVL_FULL 13'sh0800
`define DPC_LVL_LOW 13'sh1C00
`define DPC_LVL_HIGH 13'sh0400
// ----------------------------------------
// Timing
// ----------------------------------------
`define DPC_CLK_PERIOD_NS 20
`define DPC_PS_PER_NS 1000
`define DPC_NS_PER_S 1000000000
`define DPC_SLEW_UNITS (`DPC_NS_PER_S / (`DPC_PS_PER_NS * `DPC_CLK_PERIOD_NS))
`define DPC_COEF_FRAC_BITS 16
`endif

// File: hw/dpc_pkg.sv
package dpc_pkg;
  typedef struct packed {
    logic [15:0] frac;
    logic [4:0] negExp;
  } dpc_coef_t;

  typedef struct packed {
    logic [29:0] refDiv;
    logic [19:0] fbInt;
    logic [9:0] fbNum;
    logic [9:0] fbDen;
    logic [15:0] lockThr;
    logic [7:0] fillRate;
    logic [7:0] drainRate;
    dpc_coef_t alpha;
    logic [2:0] alphaPos1;
    logic [2:0] alphaPos2;
    dpc_coef_t beta;
    dpc_coef_t gamma;
    dpc_coef_t delta;
  } dpc_profile_t;

  typedef struct packed {
    logic [39:0] fixedOfs;
    logic [15:0] step;
    logic [15:0] slew;
    logic [7:0] rdData;
    logic [29:0] refCnt;
    logic [20:0] fbCnt;
    logic [10:0] fracAcc;
    logic fbExtra;
    logic haveRef;
    logic haveFb;
    logic [39:0] refWord;
    logic [39:0] fbWord;
    logic signed [39:0] incAccum;
    logic signed [39:0] applied;
    logic [17:0] budget;
    logic signed [39:0] err;
    logic errValid;
    logic signed [47:0] i1;
    logic signed [47:0] x2;
    logic signed [47:0] x3;
    logic signed [47:0] ftw;
    logic ftwValid;
    logic signed [12:0] level;
    logic locked;
  } dpc_state_t;
endpackage

// File: hw/dpc_core.sv
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_core
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Active profile and operating mode
  input wire dpc_profile_t profile,
  input wire logic freeRun,
  input wire logic holdover,
  input wire logic switchover,
  // Multifunction pins
  input wire logic mfpInc,
  input wire logic mfpDec,
  input wire logic mfpClr,
  // Reference side
  input wire logic refEdge,
  input wire logic [39:0] tdcWord,
  // Synthesizer side
  input wire logic ddsRollover,
  input wire logic [39:0] ddsWord,
  output logic [47:0] tuningWord,
  output logic tuningValid,
  output logic [39:0] phaseErr,
  output logic phaseErrValid,
  output logic phaseLocked
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic signed [47:0] coefApply(input logic signed [47:0] x, input dpc_coef_t c);
    logic signed [64:0] p;
    p = x * $signed({1'b0, c.frac});
    p = p >>> (`DPC_COEF_FRAC_BITS + c.negExp);
    return p[47:0];
  endfunction

  function automatic logic [39:0] absVal(input logic signed [39:0] v);
    return v[39] ? 40'(-v) : v;
  endfunction

  dpc_state_t st_reg, st_next;

  logic ctrlWr, incReq, decReq, clrReq, refDivEdge, fbDivEdge, inThr, modeOk;
  logic signed [39:0] target;
  logic signed [47:0] errExt, fltP, fltI1, fltX2, fltX3;
  logic [11:0] fracSum;

  // ----------------------------------------
  // Offset controls
  // ----------------------------------------
  assign ctrlWr = regWrEn && (regAddr == `DPC_ADDR_CTRL);
  assign incReq = (ctrlWr && regWrData[`DPC_BIT_INC]) || mfpInc;
  assign decReq = (ctrlWr && regWrData[`DPC_BIT_DEC]) || mfpDec;
  assign clrReq = (ctrlWr && regWrData[`DPC_BIT_CLR]) || mfpClr;
  assign target = $signed(st_reg.fixedOfs) + st_reg.incAccum;

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  assign refDivEdge = refEdge && (st_reg.refCnt == profile.refDiv);
  assign fbDivEdge = ddsRollover && (st_reg.fbCnt == {1'b0, profile.fbInt} + 21'(st_reg.fbExtra));
  assign fracSum = {1'b0, st_reg.fracAcc} + {2'h0, profile.fbNum};

  // ----------------------------------------
  // Loop filter
  // ----------------------------------------
  assign errExt = {{8{st_reg.err[39]}}, st_reg.err};
  // Widen before adding: two 3-bit exponents can sum past seven
  assign fltP = coefApply(errExt, profile.alpha) <<< (4'(profile.alphaPos1) + 4'(profile.alphaPos2));
  assign fltI1 = st_reg.i1 + coefApply(errExt, profile.beta);
  assign fltX2 = st_reg.x2 + coefApply(fltP + fltI1 - st_reg.x2, profile.gamma);
  assign fltX3 = st_reg.x3 + coefApply(fltX2 - st_reg.x3, profile.delta);

  // ----------------------------------------
  // Lock detector inputs
  // ----------------------------------------
  assign inThr = absVal(st_reg.err) <= {24'h0, profile.lockThr};
  assign modeOk = !freeRun && !holdover && !switchover;

  always_comb begin
    st_next = st_reg;
    st_next.errValid = 1'b0;
    st_next.ftwValid = 1'b0;
    // Register writes, low byte at lowest address
    if (regWrEn) begin
      for (int i = 0; i < `DPC_FIXED_BYTES; i++) begin
        if (regAddr == `DPC_ADDR_FIXED + 12'(i)) begin
          st_next.fixedOfs[8*i +: 8] = regWrData;
        end
      end
      for (int i = 0; i < `DPC_STEP_BYTES; i++) begin
        if (regAddr == `DPC_ADDR_STEP + 12'(i)) begin
          st_next.step[8*i +: 8] = regWrData;
        end
        if (regAddr == `DPC_ADDR_SLEW + 12'(i)) begin
          st_next.slew[8*i +: 8] = regWrData;
        end
      end
    end
    // Register reads; control bits never store, so they read zero
    if (regRdEn) begin
      st_next.rdData = 8'h00;
      for (int i = 0; i < `DPC_FIXED_BYTES; i++) begin
        if (regAddr == `DPC_ADDR_FIXED + 12'(i)) begin
          st_next.rdData = st_reg.fixedOfs[8*i +: 8];
        end
      end
      for (int i = 0; i < `DPC_STEP_BYTES; i++) begin
        if (regAddr == `DPC_ADDR_STEP + 12'(i)) begin
          st_next.rdData = st_reg.step[8*i +: 8];
        end
        if (regAddr == `DPC_ADDR_SLEW + 12'(i)) begin
          st_next.rdData = st_reg.slew[8*i +: 8];
        end
      end
      if (regAddr == `DPC_ADDR_STATUS) begin
        st_next.rdData[`DPC_BIT_LOCKED] = st_reg.locked;
      end
    end
    // Incremental offset; clear wins, inc and dec together cancel
    if (clrReq) begin
      st_next.incAccum = 40'sh0;
    end else if (incReq && !decReq) begin
      st_next.incAccum = st_reg.incAccum + $signed({24'h0, st_reg.step});
    end else if (decReq && !incReq) begin
      st_next.incAccum = st_reg.incAccum - $signed({24'h0, st_reg.step});
    end
    // Slew limiter: one picosecond per budget of units
    if (st_reg.slew == 16'h0000) begin
      st_next.applied = target;
      st_next.budget = 18'h0;
    end else if (st_reg.applied == target) begin
      st_next.budget = 18'h0;
    end else if (st_reg.budget >= 18'(`DPC_SLEW_UNITS)) begin
      st_next.budget = st_reg.budget - 18'(`DPC_SLEW_UNITS);
      st_next.applied = (target > st_reg.applied) ? st_reg.applied + 40'sh1 : st_reg.applied - 40'sh1;
    end else begin
      st_next.budget = st_reg.budget + {2'h0, st_reg.slew};
    end
    // Reference divider
    if (refEdge) begin
      st_next.refCnt = refDivEdge ? 30'h0 : st_reg.refCnt + 30'h1;
    end
    // Feedback divider with fractional carry
    if (ddsRollover) begin
      st_next.fbCnt = st_reg.fbCnt + 21'h1;
      if (fbDivEdge) begin
        st_next.fbCnt = 21'h0;
        st_next.fbExtra = 1'b0;
        st_next.fracAcc = fracSum[10:0];
        if (profile.fbDen != 10'h000 && fracSum >= {2'h0, profile.fbDen}) begin
          st_next.fracAcc = 11'(fracSum - {2'h0, profile.fbDen});
          st_next.fbExtra = 1'b1;
        end
      end
    end
    // Phase detector pairs one reference and one feedback word
    if (st_reg.haveRef && st_reg.haveFb) begin
      st_next.err = $signed(st_reg.refWord) - $signed(st_reg.fbWord) - st_reg.applied;
      st_next.errValid = 1'b1;
      st_next.haveRef = 1'b0;
      st_next.haveFb = 1'b0;
    end
    // New edge wins over the pairing clear
    if (refDivEdge) begin
      st_next.refWord = tdcWord;
      st_next.haveRef = 1'b1;
    end
    if (fbDivEdge) begin
      st_next.fbWord = ddsWord;
      st_next.haveFb = 1'b1;
    end
    // Code pump into integrator and filter chain
    if (st_reg.errValid) begin
      st_next.i1 = fltI1;
      st_next.x2 = fltX2;
      st_next.x3 = fltX3;
      st_next.ftw = fltX3;
      st_next.ftwValid = 1'b1;
    end
    // Lock detector
    if (freeRun || holdover) begin
      st_next.level = `DPC_LVL_EMPTY;
      st_next.locked = 1'b0;
    end else if (switchover) begin
      st_next.level = st_reg.level;
    end else if (st_reg.errValid) begin
      if (inThr) begin
        st_next.level = st_reg.level + $signed({5'h00, profile.fillRate});
        if (st_next.level > `DPC_LVL_FULL) begin
          st_next.level = `DPC_LVL_FULL;
        end
      end else begin
        st_next.level = st_reg.level - $signed({5'h00, profile.drainRate});
        if (st_next.level < `DPC_LVL_EMPTY) begin
          st_next.level = `DPC_LVL_EMPTY;
        end
      end
      if (st_next.level > `DPC_LVL_HIGH) begin
        st_next.locked = 1'b1;
      end else if (st_next.level < `DPC_LVL_LOW) begin
        st_next.locked = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.level <= `DPC_LVL_EMPTY;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign tuningWord = st_reg.ftw;
  assign tuningValid = st_reg.ftwValid;
  assign phaseErr = st_reg.err;
  assign phaseErrValid = st_reg.errValid;
  assign phaseLocked = st_reg.locked;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  incStep_a: assert property (ctrlWr && regWrData == 8'h01 && !mfpDec && !mfpClr
    |=> st_reg.incAccum == $past(st_reg.incAccum) + $signed({24'h0, $past(st_reg.step)}))
    else $error("increment did not add one step");
  decStep_a: assert property (ctrlWr && regWrData == 8'h02 && !mfpInc && !mfpClr
    |=> st_reg.incAccum == $past(st_reg.incAccum) - $signed({24'h0, $past(st_reg.step)}))
    else $error("decrement did not subtract one step");
  ctrlSelfClear_a: assert property (regRdEn && regAddr == `DPC_ADDR_CTRL |=> regRdData == 8'h00)
    else $error("control register did not read zero");
  offsetClear_a: assert property (clrReq |=> st_reg.incAccum == 40'sh0)
    else $error("clear left offset nonzero");
  slewOff_a: assert property (st_reg.slew == 16'h0000 && $stable(st_reg.slew) |=> st_reg.applied == $past(target))
    else $error("offset not applied directly with limiter off");
  slewCap_a: assert property ($past(st_reg.slew) != 16'h0000
    |-> absVal(st_reg.applied - $past(st_reg.applied)) <= 40'h1)
    else $error("offset moved faster than limiter allows");
  levelRange_a: assert property (st_reg.level >= `DPC_LVL_EMPTY && st_reg.level <= `DPC_LVL_FULL)
    else $error("lock level out of range");
  lockHigh_a: assert property (st_reg.level > `DPC_LVL_HIGH |-> st_reg.locked)
    else $error("not locked above high mark");
  unlockLow_a: assert property (st_reg.level < `DPC_LVL_LOW |-> !st_reg.locked)
    else $error("locked below low mark");
  fillOnce_a: assert property (st_reg.errValid && modeOk && inThr && st_reg.level < 13'sh0000
    |=> st_reg.level == $past(st_reg.level) + $signed({5'h00, $past(profile.fillRate)}))
    else $error("fill amount wrong");
  drainOnce_a: assert property (st_reg.errValid && modeOk && !inThr && st_reg.level > 13'sh0000
    |=> st_reg.level == $past(st_reg.level) - $signed({5'h00, $past(profile.drainRate)}))
    else $error("drain amount wrong");
  freeRunUnlock_a: assert property (freeRun || holdover |=> !st_reg.locked && st_reg.level == `DPC_LVL_EMPTY)
    else $error("lock held in free-run or holdover");
  switchHold_a: assert property (switchover && !freeRun && !holdover |=> $stable(st_reg.locked))
    else $error("lock changed during switchover");
  filterFollow_a: assert property (st_reg.errValid |=> tuningValid ##1 (!tuningValid || $past(st_reg.errValid)))
    else $error("tuning word not produced after sample");

  lockRise_c: cover property ($rose(st_reg.locked));
  sampleMade_c: cover property (st_reg.errValid ##1 tuningValid);
  slewWalk_c: cover property (st_reg.slew != 16'h0000 && st_reg.applied != target ##1 $changed(st_reg.applied));
  fracCarry_c: cover property (fbDivEdge && st_next.fbExtra);
endmodule

// File: tb/dpc_far_model.sv
`timescale 1ns/1ps
module dpc_far_model (
  // Clock
  input wire logic mclk,
  // Reference side
  output logic refEdge,
  output logic [39:0] tdcWord,
  // Synthesizer side
  output logic ddsRollover,
  output logic [39:0] ddsWord
);
  initial begin
    refEdge = 1'b0;
    ddsRollover = 1'b0;
    tdcWord = 40'h0;
    ddsWord = 40'h0;
  end

  // Only the last edge of a divided period carries the real word, so a
  // divider that samples too early picks up the inverse instead
  task automatic send(input int nRef, input int nFb, input logic [39:0] r, input logic [39:0] f);
    for (int i = 0; i < nRef; i++) begin
      @(posedge mclk);
      refEdge <= 1'b1;
      tdcWord <= (i == nRef - 1) ? r : ~r;
      @(posedge mclk);
      refEdge <= 1'b0;
      tdcWord <= ~r;
    end
    for (int i = 0; i < nFb; i++) begin
      @(posedge mclk);
      ddsRollover <= 1'b1;
      ddsWord <= (i == nFb - 1) ? f : ~f;
      @(posedge mclk);
      ddsRollover <= 1'b0;
      ddsWord <= ~f;
    end
  endtask
endmodule

// File: tb/digital_pll_core_lock_detect_tb.sv
`timescale 1ns/1ps
`include "dpc_defs.svh"
module digital_pll_core_lock_detect_tb
  import dpc_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk, reset_n, regWrEn, regRdEn;
  logic refEdge, ddsRollover, tuningValid, phaseErrValid, phaseLocked;
  logic [2:0] pins, mode;
  logic [11:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [39:0] tdcWord, ddsWord, phaseErr, errSeen;
  logic [47:0] tuningWord;
  dpc_profile_t profile;
  int n_errors = 0;
  int n_tests = 0;

  dpc_core i_dut (
    .mclk(mclk), .reset_n(reset_n),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .profile(profile), .freeRun(mode[0]), .holdover(mode[1]), .switchover(mode[2]),
    .mfpInc(pins[0]), .mfpDec(pins[1]), .mfpClr(pins[2]),
    .refEdge(refEdge), .tdcWord(tdcWord), .ddsRollover(ddsRollover), .ddsWord(ddsWord),
    .tuningWord(tuningWord), .tuningValid(tuningValid),
    .phaseErr(phaseErr), .phaseErrValid(phaseErrValid), .phaseLocked(phaseLocked)
  );

  dpc_far_model i_far (
    .mclk(mclk), .refEdge(refEdge), .tdcWord(tdcWord), .ddsRollover(ddsRollover), .ddsWord(ddsWord)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk("regRdData", {40'h0, exp}, {40'h0, regRdData});
  endtask

  task automatic pulse(input logic [2:0] p, input bit isMode);
    @(posedge mclk);
    if (isMode)
      mode <= p;
    else
      pins <= p;
    @(posedge mclk);
    mode <= 3'h0;
    pins <= 3'h0;
  endtask

  // Feedback word fixed at 400; one divided period of each side per sample
  task automatic sample(input logic [39:0] r, input logic [39:0] exp, input int nFb = 8);
    int nErr;
    int nTune;
    nErr = 0;
    nTune = 0;
    i_far.send(2, nFb, r, 40'd400);
    repeat (12) begin
      @(posedge mclk);
      #1;
      if (phaseErrValid === 1'b1) begin
        nErr++;
        errSeen = phaseErr;
      end
      if (tuningValid === 1'b1)
        nTune++;
    end
    chk("phaseErrValid", 48'h1, 48'(nErr));
    chk("phaseErr", {8'h0, exp}, {8'h0, errSeen});
    chk("tuningValid", 48'h1, 48'(nTune));
  endtask

  // Fill samples sit at minus the threshold, drain samples one above it
  task automatic run(input int n, input bit fill, input logic expLock);
    repeat (n)
      sample(fill ? 40'd100 : 40'd301, fill ? 40'hFF_FFFF_FF9C : 40'h65);
    chk("phaseLocked", {47'h0, expLock}, {47'h0, phaseLocked});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 9; i++)
      rdc(12'h30F + 12'(i), 8'h00);
    rdc(`DPC_ADDR_STATUS, 8'h00);
    chk("phaseLocked", 48'h0, {47'h0, phaseLocked});
  endtask

  task automatic t_regs();
    logic [39:0] fx;
    fx = 40'hFF_FFFF_FF38;
    for (int i = 0; i < 5; i++)
      wr(12'h30F + 12'(i), fx[8*i+:8]);
    wr(12'h314, 8'h32);
    wr(12'h315, 8'h00);
    for (int i = 0; i < 5; i++)
      rdc(12'h30F + 12'(i), fx[8*i+:8]);
    rdc(12'h314, 8'h32);
    wr(12'h123, 8'h5A);
    rdc(12'h123, 8'h00);
  endtask

  task automatic t_offset();
    sample(40'd1000, 40'd800);
    wr(`DPC_ADDR_CTRL, 8'h01);
    rdc(`DPC_ADDR_CTRL, 8'h00);
    wr(`DPC_ADDR_CTRL, 8'h01);
    wr(`DPC_ADDR_CTRL, 8'h02);
    wr(`DPC_ADDR_CTRL, 8'h03);
    pulse(3'b001, 1'b0);
    sample(40'd1000, 40'd700);
    pulse(3'b010, 1'b0);
    wr(`DPC_ADDR_CTRL, 8'h05);
    sample(40'd1000, 40'd800);
    wr(`DPC_ADDR_CTRL, 8'h01);
    pulse(3'b100, 1'b0);
    sample(40'd1000, 40'd800);
  endtask

  task automatic t_lock();
    run(12, 1'b1, 1'b0);
    run(1, 1'b1, 1'b1);
    pulse(3'b001, 1'b1);
    @(posedge mclk);
    #1;
    chk("phaseLocked", 48'h0, {47'h0, phaseLocked});
    run(12, 1'b1, 1'b0);
    run(5, 1'b1, 1'b1);
    @(posedge mclk);
    mode <= 3'b100;
    run(13, 1'b0, 1'b1);
    @(posedge mclk);
    mode <= 3'b000;
    run(12, 1'b0, 1'b1);
    run(1, 1'b0, 1'b0);
    run(13, 1'b1, 1'b1);
    pulse(3'b010, 1'b1);
    @(posedge mclk);
    #1;
    chk("phaseLocked", 48'h0, {47'h0, phaseLocked});
  endtask

  // Slowest slew never moves the offset within one sample
  task automatic t_slew();
    wr(`DPC_ADDR_SLEW, 8'h01);
    wr(`DPC_ADDR_CTRL, 8'h01);
    sample(40'd1000, 40'd800);
    wr(`DPC_ADDR_SLEW, 8'h00);
    sample(40'd1000, 40'd750);
  endtask

  // Fresh reset clears filter state; half fraction makes every second period one longer
  task automatic t_filter();
    @(posedge mclk);
    reset_n <= 1'b0;
    profile.alphaPos1 <= 3'h4;
    profile.alphaPos2 <= 3'h4;
    profile.beta.negExp <= 5'h01;
    profile.gamma.frac <= 16'h8000;
    profile.delta.frac <= 16'h8000;
    profile.fbNum <= 10'h001;
    profile.fbDen <= 10'h002;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(`DPC_ADDR_STEP, 8'h00);
    chk("phaseLocked", 48'h0, {47'h0, phaseLocked});
    sample(40'd1000, 40'd600);
    chk("tuningWord", 48'h2589, tuningWord);
    sample(40'd1000, 40'd600);
    sample(40'd1000, 40'd600, 9);
  endtask

  // ----------------------------------------
  // Run
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    pins = 3'h0;
    mode = 3'h0;
    profile = '0;
    profile.refDiv = 30'h1;
    profile.fbInt = 20'h7;
    profile.lockThr = 16'h64;
    profile.fillRate = 8'hFF;
    profile.drainRate = 8'hFF;
    profile.alpha.frac = 16'h4000;
    profile.beta.frac = 16'h2000;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_offset();
    t_lock();
    t_slew();
    t_filter();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule
